// File: bench/dpiw_cpu_model.sv
`timescale 1ns/10ps
// ****************************************************************
// processor side: nmi handler that feeds the watchdog
// ****************************************************************
module dpiw_cpu_model (
    input  wire logic              ref_clk_i,
    input  wire logic              nmi_i,
    input  wire logic [1:0]        mode_i,     // 0 silent, 1 serves, 2 wrong value
    output dpiw_pkg::dpiw_port_wr_t port_wr_o,
    output logic                   nmi_ack_o
);
    // handler: short entry, optional port write, then acknowledge
    initial
    begin
        port_wr_o = '0;
        nmi_ack_o = 1'b0;
        forever
        begin
            @(negedge ref_clk_i);
            if (nmi_i === 1'b1)
            begin
                repeat (3) @(negedge ref_clk_i);
                // silent mode stands for a spin counter that stopped
                if (mode_i != 2'h0)
                begin
                    port_wr_o = '{1'b1, dpiw_pkg::WD_SERVICE_ADDR,
                        (mode_i == 2'h1) ? dpiw_pkg::WD_SERVICE_VAL : 8'h0e};
                    @(negedge ref_clk_i);
                    // released bus shows inverted values, never the old ones
                    port_wr_o = '{1'b0, ~port_wr_o.addr, ~port_wr_o.data};
                end
                nmi_ack_o = 1'b1;
                @(negedge ref_clk_i);
                nmi_ack_o = 1'b0;
                wait (nmi_i !== 1'b1);
            end
        end
    end
endmodule

// File: bench/dpiw_top_assertions.sv
`timescale 1ns/10ps
// ****************************************************************
// port-level checks on the watchdog and the interrupt lines
// ****************************************************************
module dpiw_top_assertions #(
    parameter int unsigned RST_PULSE_CYC = 4
) (
    input wire logic                    ref_clk_i,
    input wire logic                    nrst_i,
    input wire dpiw_pkg::dpiw_port_wr_t port_wr_i,
    input wire logic                    nmi_ack_i,
    input wire logic [7:0]              irq_ack_i,
    input wire logic                    timer2_i,
    input wire logic                    nmi_o,
    input wire logic                    cpu_reset_o,
    input wire logic [7:0]              irq_o,
    input wire logic [2:0]              irq_top_o,
    input wire logic                    irq_any_o
);
    logic [15:0] rst_len_r;    // cycles the processor reset has stood
    logic [15:0] rst_len_nxt;  // next value of the width counter

    // counter restarts whenever the reset pulse is low
    always_comb rst_len_nxt = cpu_reset_o ? rst_len_r + 16'h0001 : 16'h0000;
    always_ff @(posedge ref_clk_i) rst_len_r <= nrst_i ? rst_len_nxt : 16'h0000;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // accepted service write, only the exact port and value count
    sequence s_service;
        port_wr_i.wr && port_wr_i.addr == dpiw_pkg::WD_SERVICE_ADDR
            && port_wr_i.data == dpiw_pkg::WD_SERVICE_VAL;
    endsequence
    sequence s_quiet;
        !cpu_reset_o [*8];
    endsequence

    a_service_no_reset: assert property (nmi_o ##0 s_service |=> s_quiet)
        else $error("reset followed a good service write");
    a_reset_width: assert property ($fell(cpu_reset_o) |-> rst_len_r == RST_PULSE_CYC)
        else $error("processor reset pulse has wrong width");
    a_reset_drops_nmi: assert property ($rose(cpu_reset_o) |-> ##[0:1] !nmi_o)
        else $error("nmi still raised in reset phase");
    a_nmi_ack_clear: assert property (nmi_ack_i |=> !nmi_o)
        else $error("nmi not cleared by acknowledge");
    a_irq_latency: assert property ($rose(timer2_i) |-> ##3 irq_o[7])
        else $error("lowest line not pending three edges after timer");
    // a timer edge that lands on the ack cycle wins, so that cycle is left out
    a_ack_clears_irq: assert property (irq_ack_i[7] && !($past(timer2_i, 2) && !$past(timer2_i, 3)) |=> !irq_o[7])
        else $error("lowest line not cleared by acknowledge");
    a_top_cmd_line: assert property (irq_o[0] |-> irq_top_o == 3'h0)
        else $error("command line pending but not reported on top");
    a_any_matches: assert property (irq_any_o == (irq_o != 8'h00))
        else $error("any-pending flag disagrees with pending lines");
endmodule

bind dpiw_top dpiw_top_assertions #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .port_wr_i(port_wr_i), .nmi_ack_i(nmi_ack_i),
    .irq_ack_i(irq_ack_i), .timer2_i(timer2_i), .nmi_o(nmi_o), .cpu_reset_o(cpu_reset_o),
    .irq_o(irq_o), .irq_top_o(irq_top_o), .irq_any_o(irq_any_o));

// File: bench/dpiw_top_tb.sv
`timescale 1ns/10ps
module dpiw_top_tb;
    localparam int WDP = 100;   // shortened watchdog period
    localparam int WDW = 20;    // shortened service window
    localparam int SC  = 5000;  // shortened sector period
    localparam int RSTP = 4;    // shortened reset pulse
    logic                    ref_clk_i = 1'b0;  // low from the start, so time zero has no edge
    logic                    nrst_i;
    logic [7:0]              ev;        // event inputs in irq_o bit order
    logic [7:0]              irq_ack;
    logic [1:0]              mode;
    logic [3:0]              sec_num, sec_off, sector_o, s0;
    dpiw_pkg::dpiw_port_wr_t port_wr;
    logic                    nmi_ack, nmi_o, cpu_reset_o, irq_any_o;
    logic [7:0]              irq_o, latch_src;
    logic [2:0]              irq_top_o;
    dpiw_pkg::dpiw_mag_vec_t mag_o;
    logic [7:0]              lu_src_in; // latchup source at the pins
    dpiw_pkg::dpiw_mag_vec_t mag_in;    // field vector at the pins
    int                      miscompares, check_count, n;

    dpiw_top #(.WD_PERIOD_CYC(WDP), .WD_WINDOW_CYC(WDW), .SECTOR_CYC(SC),
        .RST_PULSE_CYC(RSTP)) uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .port_wr_i(port_wr), .nmi_ack_i(nmi_ack), .irq_ack_i(irq_ack),
        .cmd_word_ready_i(ev[0]), .timer0_i(ev[1]), .spin_segment_clock_i(ev[2]),
        .sector_number_set_i(sec_num), .sector_offset_set_i(sec_off),
        .class_parity_err_i(ev[3]), .timer1_i(ev[4]), .latchup_i(ev[5]),
        .latchup_source_i(lu_src_in), .frame_reset_i(ev[6]), .mag_vec_i(mag_in),
        .timer2_i(ev[7]), .nmi_o(nmi_o), .cpu_reset_o(cpu_reset_o), .irq_o(irq_o),
        .irq_top_o(irq_top_o), .irq_any_o(irq_any_o), .sector_o(sector_o),
        .latchup_source_o(latch_src), .mag_vec_o(mag_o));
    dpiw_cpu_model cpu (.ref_clk_i(ref_clk_i), .nmi_i(nmi_o), .mode_i(mode),
        .port_wr_o(port_wr), .nmi_ack_o(nmi_ack));

    // ****************************************************************
    // shared helpers
    // ****************************************************************
    task automatic step(input int k);
        repeat (k) @(negedge ref_clk_i);
    endtask
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // bounded wait on nmi (0), processor reset (1) or sector line (2)
    task automatic count_until(input int w, output int k);
        k = 0;
        while (((w == 0) ? nmi_o : (w == 1) ? cpu_reset_o : irq_o[2]) !== 1'b1 && k < 9000)
        begin
            step(1);
            k++;
        end
        // a wait that runs out is a failure in its own right
        if (k >= 9000)
        begin
            miscompares++;
            $display("[FAIL] %0t wait limit reached", $time);
        end
    endtask
    task automatic pulse_ack(input logic [7:0] m);
        irq_ack = m;
        step(1);
        irq_ack = 8'h00;
    endtask
    task automatic summarize();
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_watchdog();
        count_until(0, n);
        chk(n >= WDP - 1 && n <= WDP + 1, "nmi period");
        step(60);
        chk(cpu_reset_o === 1'b0, "reset despite service");
        mode = 2'h2;                 // wrong value must be ignored
        count_until(0, n);
        count_until(1, n);
        chk(n >= WDW - 1 && n <= WDW + 1, "reset after window");
        mode = 2'h1;
        step(RSTP + 2);
        chk(cpu_reset_o === 1'b0, "reset pulse too long");
        count_until(0, n);
        chk(n >= WDP - 4 && n <= WDP, "fresh period after reset");
    endtask
    task automatic t_lines();
        for (int i = 0; i < 8; i++)
        begin
            ev[i] = 1'b1;
            step(1);
            ev[i] = 1'b0;
            step(3);
            chk(irq_o === (8'h01 << i), "pending line");
            chk(irq_top_o === 3'(i), "top index");
            pulse_ack(8'h01 << i);
            step(1);
            chk(irq_o === 8'h00, "ack does not clear");
        end
        ev = 8'hff;                  // all lines at once
        step(1);
        ev = 8'h00;
        step(3);
        chk(irq_o === 8'hff && irq_top_o === 3'h0, "priority burst");
        // pins move on after the events; the held copies must not follow
        lu_src_in = 8'ha5;
        mag_in    = 40'h0123456789;
        pulse_ack(8'h01);
        step(1);
        chk(irq_top_o === 3'h1, "second priority");
        chk(latch_src === 8'h5a, "latchup source");
        chk(mag_o === 40'h9abcdef035, "field vector");
        pulse_ack(8'hff);
    endtask
    task automatic t_sector();
        ev[2] = 1'b1;                // spin edge restarts the divider
        step(1);
        ev[2] = 1'b0;
        step(3);
        pulse_ack(8'h04);
        count_until(2, n);
        step(2);
        s0 = sector_o;
        pulse_ack(8'h04);
        count_until(2, n);
        chk(n >= SC - 4 && n <= SC - 2, "sector period");
        step(2);
        chk(sector_o === s0 + 4'h1, "sector advance");
        sec_num = 4'h3;
        sec_off = 4'h2;
        step(3);
        chk(sector_o === s0 + 4'h6, "sector number and offset");
    endtask

    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        #400000;
        miscompares++;
        summarize();
    end
    initial
    begin
        {ev, irq_ack, mode, sec_num, sec_off} = {8'h00, 8'h00, 2'h1, 4'h0, 4'h0};
        {miscompares, check_count} = {32'h0, 32'h0};
        lu_src_in = 8'h5a;
        mag_in    = 40'h9abcdef035;
        nrst_i = 1'b0;
        step(2);
        nrst_i = 1'b1;
        t_watchdog();
        t_lines();
        t_sector();
        summarize();
    end
endmodule

// File: hdl/dpiw_top.sv
`timescale 1ns/10ps
module dpiw_top #(
    parameter int unsigned WD_PERIOD_CYC = dpiw_pkg::WD_PERIOD_CYC,
    parameter int unsigned WD_WINDOW_CYC = dpiw_pkg::WD_WINDOW_CYC,
    parameter int unsigned SECTOR_CYC    = dpiw_pkg::SECTOR_CYC,
    parameter int unsigned RST_PULSE_CYC = dpiw_pkg::RST_PULSE_CYC
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    nrst_i,
    input  wire dpiw_pkg::dpiw_port_wr_t port_wr_i,
    input  wire logic                    nmi_ack_i,
    input  wire logic [7:0]              irq_ack_i,
    input  wire logic                    cmd_word_ready_i,
    input  wire logic                    timer0_i,
    input  wire logic                    spin_segment_clock_i,
    input  wire logic [3:0]              sector_number_set_i,
    input  wire logic [3:0]              sector_offset_set_i,
    input  wire logic                    class_parity_err_i,
    input  wire logic                    timer1_i,
    input  wire logic                    latchup_i,
    input  wire logic [7:0]              latchup_source_i,
    input  wire logic                    frame_reset_i,
    input  wire dpiw_pkg::dpiw_mag_vec_t mag_vec_i,
    input  wire logic                    timer2_i,
    output logic                         nmi_o,
    output logic                         cpu_reset_o,
    output logic [7:0]                   irq_o,
    output logic [2:0]                   irq_top_o,
    output logic                         irq_any_o,
    output logic [3:0]                   sector_o,
    output logic [7:0]                   latchup_source_o,
    output dpiw_pkg::dpiw_mag_vec_t      mag_vec_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    localparam int unsigned N = dpiw_pkg::IRQ_LINES;

    typedef struct packed {
        logic [N-1:0]            sync1;      // first sync stage, read only by sync2
        logic [N-1:0]            sync2;      // second sync stage
        logic [N-1:0]            prev;       // edge detect history
        logic [N-1:0]            pend;       // sticky pending lines
        logic [31:0]             wd_cnt;     // watchdog period / window counter
        dpiw_pkg::dpiw_wd_state_t wd_st;     // watchdog state
        logic                    nmi;        // nmi request
        logic                    cpu_rst;    // processor reset
        logic [31:0]             sec_cnt;    // sector period counter
        logic [3:0]              sector;     // raw sector count
        logic [2:0]              top;        // highest pending line
        logic                    any;        // any line pending
        logic [3:0]              sector_out; // adjusted sector number
        logic [7:0]              lu_src;     // captured latchup source
        dpiw_pkg::dpiw_mag_vec_t mag;        // captured field vector
    } dpiw_state_t;

    dpiw_state_t st_r;   // registered state
    dpiw_state_t st_nxt; // next state

    // ****************************************************************
    // helpers
    // ****************************************************************
    // priority encoder: lowest index wins
    function automatic logic [2:0] dpiw_first(input logic [N-1:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // gather raw event sources in priority order
    logic [N-1:0] raw_ev;
    logic         sector_tick;

    always_comb
    begin
        raw_ev                           = '0;
        raw_ev[dpiw_pkg::L_CMD]          = cmd_word_ready_i;
        raw_ev[dpiw_pkg::L_TMR0]         = timer0_i;
        raw_ev[dpiw_pkg::L_SECTOR]       = spin_segment_clock_i;
        raw_ev[dpiw_pkg::L_PARITY]       = class_parity_err_i;
        raw_ev[dpiw_pkg::L_TMR1]         = timer1_i;
        raw_ev[dpiw_pkg::L_LATCH]        = latchup_i;
        raw_ev[dpiw_pkg::L_TLM]          = frame_reset_i;
        raw_ev[dpiw_pkg::L_TMR2]         = timer2_i;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    logic [N-1:0] rise;       // rising edges of synced sources
    logic [N-1:0] pend_v;     // pending after set and clear
    logic         serviced;   // accepted service write

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.sync1 = raw_ev;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;
        rise        = st_r.sync2 & ~st_r.prev;
        sector_tick = 1'b0;

        // sector pulse from the internal 256 ms divider; a spin segment edge
        // also resynchronises it so the line follows the spacecraft clock
        if (rise[dpiw_pkg::L_SECTOR] || st_r.sec_cnt >= SECTOR_CYC - 1)
        begin
            st_nxt.sec_cnt = '0;
            sector_tick    = 1'b1;
            st_nxt.sector  = st_r.sector + 4'h1;
        end
        else
        begin
            st_nxt.sec_cnt = st_r.sec_cnt + 32'h1;
        end
        // numbering and sun offset applied separately
        st_nxt.sector_out = st_r.sector + sector_number_set_i + sector_offset_set_i;

        // set beats clear so a new event in the ack cycle is kept
        pend_v = (st_r.pend & ~irq_ack_i) | rise;
        pend_v[dpiw_pkg::L_SECTOR] = (st_r.pend[dpiw_pkg::L_SECTOR]
                                      & ~irq_ack_i[dpiw_pkg::L_SECTOR]) | sector_tick;
        st_nxt.pend = pend_v;
        st_nxt.top  = dpiw_first(pend_v);
        st_nxt.any  = |pend_v;

        // capture readable data on their events
        if (rise[dpiw_pkg::L_LATCH])
        begin
            st_nxt.lu_src = latchup_source_i;
        end
        if (rise[dpiw_pkg::L_TLM])
        begin
            st_nxt.mag = mag_vec_i;
        end

        // watchdog
        serviced = port_wr_i.wr && port_wr_i.addr == dpiw_pkg::WD_SERVICE_ADDR
                   && port_wr_i.data == dpiw_pkg::WD_SERVICE_VAL;
        // nmi stays until acked or until the window runs out into reset, new nmi wins over ack
        if (nmi_ack_i)
        begin
            st_nxt.nmi = 1'b0;
        end
        st_nxt.cpu_rst = 1'b0;
        case (st_r.wd_st)
            dpiw_pkg::WD_IDLE:
            begin
                if (st_r.wd_cnt >= WD_PERIOD_CYC - 1)
                begin
                    st_nxt.wd_cnt = '0;
                    st_nxt.nmi    = 1'b1;
                    st_nxt.wd_st  = dpiw_pkg::WD_WAIT;
                end
                else
                begin
                    st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
                end
            end
            dpiw_pkg::WD_WAIT:
            begin
                // the period keeps running while the window is open
                if (serviced)
                begin
                    st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
                    st_nxt.wd_st  = dpiw_pkg::WD_IDLE;
                end
                else if (st_r.wd_cnt >= WD_WINDOW_CYC - 1)
                begin
                    st_nxt.wd_cnt  = '0;
                    st_nxt.nmi     = 1'b0;
                    st_nxt.cpu_rst = 1'b1;
                    st_nxt.wd_st   = dpiw_pkg::WD_RESET;
                end
                else
                begin
                    st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
                end
            end
            dpiw_pkg::WD_RESET:
            begin
                // fixed width pulse, then a fresh full period
                st_nxt.nmi = 1'b0;
                if (st_r.wd_cnt >= RST_PULSE_CYC - 1)
                begin
                    st_nxt.wd_cnt = '0;
                    st_nxt.wd_st  = dpiw_pkg::WD_IDLE;
                end
                else
                begin
                    st_nxt.wd_cnt  = st_r.wd_cnt + 32'h1;
                    st_nxt.cpu_rst = 1'b1;
                end
            end
            default:
            begin
                st_nxt.wd_cnt = '0;
                st_nxt.wd_st  = dpiw_pkg::WD_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // synchronous reset; every field takes a constant
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            st_r       <= '0;
            st_r.wd_st <= dpiw_pkg::WD_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs, all straight from flip-flops
    // ****************************************************************
    assign nmi_o            = st_r.nmi;
    assign cpu_reset_o      = st_r.cpu_rst;
    assign irq_o            = st_r.pend;
    assign irq_top_o        = st_r.top;
    assign irq_any_o        = st_r.any;
    assign sector_o         = st_r.sector_out;
    assign latchup_source_o = st_r.lu_src;
    assign mag_vec_o        = st_r.mag;

endmodule

// File: shared/dpiw_pkg.sv
// ****************************************************************
// event watchdog constants and carrier types
// ****************************************************************
package dpiw_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;   // system clock rate
    localparam int unsigned WD_PERIOD_MS    = 1000;         // watchdog nmi period
    localparam int unsigned WD_PERIOD_CYC   = CLK_HZ / 1000 * WD_PERIOD_MS;
    localparam int unsigned WD_WINDOW_MS    = 500;          // service window after nmi
    localparam int unsigned WD_WINDOW_CYC   = CLK_HZ / 1000 * WD_WINDOW_MS;
    localparam int unsigned RST_PULSE_US    = 10;           // processor reset width
    localparam int unsigned RST_PULSE_CYC   = CLK_HZ / 1_000_000 * RST_PULSE_US;
    localparam int unsigned SECTOR_MS       = 256;          // sector pulse period
    localparam int unsigned SECTOR_CYC      = CLK_HZ / 1000 * SECTOR_MS;
    localparam int unsigned SECTORS         = 16;           // sectors per spin
    localparam int unsigned IRQ_LINES       = 8;            // maskable lines

    // ****************************************************************
    // service port
    // ****************************************************************
    localparam logic [7:0]  WD_SERVICE_VAL  = 8'hf1;        // value that feeds the watchdog
    localparam logic [15:0] WD_SERVICE_ADDR = 16'h00f0;     // port address, plain default

    // ****************************************************************
    // line numbers, highest priority first
    // ****************************************************************
    localparam int unsigned L_CMD    = 0;
    localparam int unsigned L_TMR0   = 1;
    localparam int unsigned L_SECTOR = 2;
    localparam int unsigned L_PARITY = 3;
    localparam int unsigned L_TMR1   = 4;
    localparam int unsigned L_LATCH  = 5;
    localparam int unsigned L_TLM    = 6;
    localparam int unsigned L_TMR2   = 7;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [11:0] bx;            // field component x
        logic [11:0] by;            // field component y
        logic [11:0] bz;            // field component z
        logic [2:0]  range_code;    // range code
        logic        trigger;       // trigger bit
    } dpiw_mag_vec_t;

    typedef struct packed {
        logic        wr;            // port write strobe
        logic [15:0] addr;          // port address
        logic [7:0]  data;          // write data
    } dpiw_port_wr_t;

    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,           // counting to next nmi
        WD_WAIT  = 2'b01,           // nmi raised, awaiting service
        WD_RESET = 2'b10            // driving processor reset
    } dpiw_wd_state_t;

endpackage
